// ### common/fls_defs.vh
// Constants for the fault log and statistics block
`ifndef FLS_DEFS_VH
`define FLS_DEFS_VH
// Register byte offsets
`define FLS_A_CTRL 6'h00
`define FLS_A_DISP 6'h04
`define FLS_A_STAT 6'h08
`define FLS_A_HIST0 6'h0C
`define FLS_A_HIST1 6'h10
`define FLS_A_HIST2 6'h14
`define FLS_A_HIST3 6'h18
`define FLS_A_HIST4 6'h1C
`define FLS_A_TSTART 6'h20
`define FLS_A_RSTART 6'h24
`define FLS_A_THOURS 6'h28
`define FLS_A_RHOURS 6'h2C
// Control register fields
`define FLS_C_CLR_LOG 0
`define FLS_C_CLR_STARTS 1
`define FLS_C_CLR_HOURS 2
`define FLS_C_KEY_EN 3
`define FLS_C_AUTO_RST 4
`define FLS_C_SW_RST 5
`define FLS_C_BLANK_LO 8
`define FLS_C_BLANK_HI 15
// Status register fields
`define FLS_S_ACTIVE 16
// Fault codes
`define FLS_F_NONE 5'h00
`define FLS_F_PHASE_LOSS 5'h01
`define FLS_F_PHASE_SEQ 5'h02
`define FLS_F_IMBALANCE 5'h03
`define FLS_F_OVERLOAD 5'h04
`define FLS_F_UNDERLOAD 5'h05
`define FLS_F_PEAK 5'h06
`define FLS_F_HEATSINK 5'h07
`define FLS_F_THERMISTOR 5'h08
`define FLS_F_SHEAR 5'h09
`define FLS_F_OVERVOLT 5'h0A
`define FLS_F_UNDERVOLT 5'h0B
`define FLS_F_STARTS 5'h0C
`define FLS_F_MEMORY 5'h0D
`define FLS_F_SCR1 5'h0E
`define FLS_F_SCR2 5'h0F
`define FLS_F_SCR3 5'h10
`define FLS_F_SCR_ANY 5'h11
`define FLS_F_SLOW_LONG 5'h12
`define FLS_F_SLOW_NA 5'h13
`define FLS_F_COMMS 5'h14
`define FLS_F_EXTERNAL 5'h15
`define FLS_F_DIP 5'h16
`define FLS_F_SWELL 5'h17
`define FLS_F_HI_PRESS 5'h18
`define FLS_F_LO_PRESS 5'h19
`define FLS_F_NO_FLOW 5'h1A
`define FLS_F_NO_WATER 5'h1B
// Status codes
`define FLS_ST_READY 5'h00
`define FLS_ST_ITQ 5'h01
`define FLS_ST_DCB 5'h08
`define FLS_ST_FAULT 5'h11
`define FLS_ST_MAX 5'h19
// Counting limits
`define FLS_LAST_SLOT 3'h4
`define FLS_LAST_SEC 6'h3B
`define FLS_LAST_MIN 6'h3B
`define FLS_MAX_HOURS 17'h1_869F
// AXI responses
`define FLS_RESP_OK 2'h0
`define FLS_RESP_ERR 2'h2
`endif

// ### rtl/fls_fault_log.v
// Fault log, fault display and start and hour statistics with an AXI4-Lite register slave
`include "fls_defs.vh"
`default_nettype none
module fls_fault_log #(
  parameter SEC_CYCLES = 125000000
) (
  input wire clk,
  input wire rst,
  input wire clk_en,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [27:1] trip_req,
  input wire [4:0] op_status,
  input wire start_pulse,
  input wire motor_running,
  input wire [15:0] avg_current,
  input wire [15:0] avg_voltage,
  input wire stop_key_pin,
  input wire ext_reset_pin,
  input wire detail_key_pin,
  output reg fault_active,
  output reg fault_led,
  output reg fault_banner,
  output reg [2:0] disp_pos,
  output reg [4:0] disp_code,
  output reg [4:0] disp_status,
  output reg disp_detail,
  output reg disp_sep_colon,
  output reg [15:0] disp_current,
  output reg [15:0] disp_voltage
);

  // Lowest set cause wins so one code is logged per trip
  function [4:0] fls_encode;
    input [27:1] v;
    integer i;
    begin
      fls_encode = `FLS_F_NONE;
      for (i = 27; i >= 1; i = i - 1)
        if (v[i])
          fls_encode = i[4:0];
    end
  endfunction

  // Hour counter step: minutes roll into hours, hours saturate
  function [22:0] fls_tick_hours;
    input [22:0] hm;
    begin
      if (hm[5:0] != `FLS_LAST_MIN)
        fls_tick_hours = {hm[22:6], hm[5:0] + 6'h01};
      else if (hm[22:6] != `FLS_MAX_HOURS)
        fls_tick_hours = {hm[22:6] + 17'h0_0001, 6'h00};
      else
        fls_tick_hours = hm;
    end
  endfunction

  reg [2:0] sync_a, sync_b, disp_sel;
  reg detail_q, key_en, auto_rst, sw_reset, aw_got, w_got, next_rerr;
  reg [9:0] hist [0:4];
  reg [7:0] blank_s, blank_cnt;
  reg [26:0] presc;
  reg [5:0] sec_cnt, aw_addr;
  reg [31:0] total_start_count, resettable_start_count, w_data, next_rdata;
  reg [22:0] total_run_hours, resettable_run_hours;
  reg clear_fault_log_ctrl, clear_start_count_ctrl, clear_run_hours_ctrl;
  reg [3:0] w_strb;
  integer k;

  wire sec_tick = ({5'h00, presc} == SEC_CYCLES - 1); // Compared at full width so no period bit is lost
  wire min_tick = sec_tick && (sec_cnt == `FLS_LAST_SEC);
  wire stop_key = sync_b[0];
  wire ext_reset = sync_b[1];
  wire detail_edge = sync_b[2] && !detail_q;
  wire wr_go = aw_got && w_got && !s_axi_bvalid;

  // Pressure trips need a running motor, flow trip waits out the blanking
  wire [27:1] trip_live = {trip_req[27], trip_req[26] && (blank_cnt == 8'h00),
                           trip_req[25:24] & {2{motor_running}}, trip_req[23:1]};
  wire [4:0] trip_code = fls_encode(trip_live);
  wire new_fault = (trip_code != `FLS_F_NONE) && !fault_active;
  wire [4:0] st_code = (op_status > `FLS_ST_MAX) ? `FLS_ST_FAULT : op_status;
  wire clear_req = (stop_key && key_en) || ext_reset || sw_reset;

  // AXI handshakes: one outstanding write and one read
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Pins from the keypad and terminals cross two flops first
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      detail_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sync_a <= {detail_key_pin, ext_reset_pin, stop_key_pin};
      sync_b <= sync_a;
      detail_q <= sync_b[2];
    end
  end

  // Read mux; unmapped offsets answer SLVERR with zero data
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    if (s_axi_araddr == `FLS_A_CTRL)
      next_rdata = {16'h0000, blank_s, 2'h0, sw_reset, auto_rst, key_en, clear_run_hours_ctrl,
                    clear_start_count_ctrl, clear_fault_log_ctrl};
    else if (s_axi_araddr == `FLS_A_DISP)
      next_rdata = {29'h0000_0000, disp_sel};
    else if (s_axi_araddr == `FLS_A_STAT)
      next_rdata = {15'h0000, fault_active, 3'h0, hist[0][9:5], 3'h0, hist[0][4:0]};
    else if (s_axi_araddr == `FLS_A_HIST0)
      next_rdata = {19'h0_0000, hist[0][9:5], 3'h0, hist[0][4:0]};
    else if (s_axi_araddr == `FLS_A_HIST1)
      next_rdata = {19'h0_0000, hist[1][9:5], 3'h0, hist[1][4:0]};
    else if (s_axi_araddr == `FLS_A_HIST2)
      next_rdata = {19'h0_0000, hist[2][9:5], 3'h0, hist[2][4:0]};
    else if (s_axi_araddr == `FLS_A_HIST3)
      next_rdata = {19'h0_0000, hist[3][9:5], 3'h0, hist[3][4:0]};
    else if (s_axi_araddr == `FLS_A_HIST4)
      next_rdata = {19'h0_0000, hist[4][9:5], 3'h0, hist[4][4:0]};
    else if (s_axi_araddr == `FLS_A_TSTART)
      next_rdata = total_start_count;
    else if (s_axi_araddr == `FLS_A_RSTART)
      next_rdata = resettable_start_count;
    else if (s_axi_araddr == `FLS_A_THOURS)
      next_rdata = {7'h00, total_run_hours[22:6], 2'h0, total_run_hours[5:0]};
    else if (s_axi_araddr == `FLS_A_RHOURS)
      next_rdata = {7'h00, resettable_run_hours[22:6], 2'h0, resettable_run_hours[5:0]};
    else
      next_rerr = 1'b1;
  end

  // Read channel: data one cycle after the address is taken
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FLS_RESP_OK;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? `FLS_RESP_ERR : `FLS_RESP_OK;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Write channel and register file; address and data may come in either order
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FLS_RESP_OK;
      key_en <= 1'b1;
      auto_rst <= 1'b0;
      blank_s <= 8'h00;
      disp_sel <= 3'h0;
      clear_fault_log_ctrl <= 1'b0;
      clear_start_count_ctrl <= 1'b0;
      clear_run_hours_ctrl <= 1'b0;
      sw_reset <= 1'b0;
    end
    else if (clk_en)
    begin
      // One-shot controls drop back to no after their single cycle
      clear_fault_log_ctrl <= 1'b0;
      clear_start_count_ctrl <= 1'b0;
      clear_run_hours_ctrl <= 1'b0;
      sw_reset <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `FLS_RESP_OK;
        if (aw_addr == `FLS_A_CTRL)
        begin
          if (w_strb[0])
          begin
            clear_fault_log_ctrl <= w_data[`FLS_C_CLR_LOG];
            clear_start_count_ctrl <= w_data[`FLS_C_CLR_STARTS];
            clear_run_hours_ctrl <= w_data[`FLS_C_CLR_HOURS];
            key_en <= w_data[`FLS_C_KEY_EN];
            auto_rst <= w_data[`FLS_C_AUTO_RST];
            sw_reset <= w_data[`FLS_C_SW_RST];
          end
          if (w_strb[1])
            blank_s <= w_data[`FLS_C_BLANK_HI:`FLS_C_BLANK_LO];
        end
        else if ((aw_addr == `FLS_A_DISP) && w_strb[0] && (w_data[2:0] <= `FLS_LAST_SLOT))
          disp_sel <= w_data[2:0]; // Out-of-range slots are ignored rather than wrapped
        else if (aw_addr[5:2] > (`FLS_A_RHOURS >> 2))
          s_axi_bresp <= `FLS_RESP_ERR;
      end
      // A trip overrides any slot the operator had chosen
      if (new_fault)
        disp_sel <= 3'h0;
    end
  end

  // Fault state, history and frozen readings
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_active <= 1'b0;
      fault_led <= 1'b0;
      fault_banner <= 1'b0;
      disp_current <= 16'h0000;
      disp_voltage <= 16'h0000;
      for (k = 0; k < 5; k = k + 1)
        hist[k] <= 10'h000;
    end
    else if (clk_en)
    begin
      // A new trip wins over a reset that lands in the same cycle
      if (new_fault)
      begin
        fault_active <= 1'b1;
        fault_led <= 1'b1;
        fault_banner <= 1'b1;
      end
      else if (clear_req)
      begin
        fault_active <= 1'b0;
        fault_led <= 1'b0;
        fault_banner <= 1'b0;
      end
      // Readings track live values until a trip, then hold
      if (!fault_active)
      begin
        disp_current <= avg_current;
        disp_voltage <= avg_voltage;
      end
      if (clear_fault_log_ctrl)
        for (k = 0; k < 5; k = k + 1)
          hist[k] <= 10'h000;
      else if (new_fault)
        for (k = 4; k > 0; k = k - 1)
          hist[k] <= hist[k - 1];
      if (new_fault)
        hist[0] <= {st_code, trip_code};
    end
  end

  // Display outputs come from flops; detail key toggles the numeric view
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      disp_pos <= 3'h1;
      disp_code <= `FLS_F_NONE;
      disp_status <= `FLS_ST_READY;
      disp_detail <= 1'b0;
      disp_sep_colon <= 1'b0;
    end
    else if (clk_en)
    begin
      disp_pos <= disp_sel + 3'h1;
      disp_code <= hist[disp_sel][4:0];
      disp_status <= hist[disp_sel][9:5];
      disp_sep_colon <= auto_rst;
      if (new_fault)
        disp_detail <= 1'b0;
      else if (detail_edge)
        disp_detail <= !disp_detail;
    end
  end

  // Second prescaler and flow-switch blanking after a start
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      presc <= 27'h000_0000;
      sec_cnt <= 6'h00;
      blank_cnt <= 8'h00;
    end
    else if (clk_en)
    begin
      presc <= sec_tick ? 27'h000_0000 : presc + 27'h000_0001;
      if (sec_tick)
        sec_cnt <= min_tick ? 6'h00 : sec_cnt + 6'h01;
      if (start_pulse)
        blank_cnt <= blank_s;
      else if (sec_tick && (blank_cnt != 8'h00))
        blank_cnt <= blank_cnt - 8'h01;
    end
  end

  // Start and run-time counters; only the second ones can be cleared
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      total_start_count <= 32'h0000_0000;
      resettable_start_count <= 32'h0000_0000;
      total_run_hours <= 23'h00_0000;
      resettable_run_hours <= 23'h00_0000;
    end
    else if (clk_en)
    begin
      if (start_pulse)
        total_start_count <= total_start_count + 32'h0000_0001;
      if (start_pulse) // A start in the clear cycle still counts
        resettable_start_count <= clear_start_count_ctrl ? 32'h0000_0001
                                  : resettable_start_count + 32'h0000_0001;
      else if (clear_start_count_ctrl)
        resettable_start_count <= 32'h0000_0000;
      if (motor_running && min_tick)
        total_run_hours <= fls_tick_hours(total_run_hours);
      if (clear_run_hours_ctrl)
        resettable_run_hours <= 23'h00_0000;
      else if (motor_running && min_tick)
        resettable_run_hours <= fls_tick_hours(resettable_run_hours);
    end
  end

endmodule
`default_nettype wire

// ### sim/fls_fault_log_monitor.sv
// Assertions on the fault log ports
`default_nettype none
module fls_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [27:1] trip_req,
  input wire logic [4:0] op_status,
  input wire logic motor_running,
  input wire logic [15:0] avg_current,
  input wire logic ext_reset_pin,
  input wire logic fault_active,
  input wire logic fault_led,
  input wire logic fault_banner,
  input wire logic [2:0] disp_pos,
  input wire logic [4:0] disp_code,
  input wire logic [4:0] disp_status,
  input wire logic disp_detail,
  input wire logic [15:0] disp_current
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low;
  logic [4:0] st;
  logic ok;
  // Lowest set request bit is the code that gets logged
  always_comb
  begin
    low = 5'h00;
    for (int i = 27; i > 0; i--)
      if (trip_req[i])
        low = 5'(i);
  end
  // Flow code hides behind its blanking timer, pressure codes need a running motor
  assign ok = low != 5'h00 && low != 5'h1A && (motor_running || low < 5'h18 || low > 5'h19);
  assign st = (op_status > 5'h19) ? 5'h11 : op_status;
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !clk_en);
  sequence s_trip;
    ok && !fault_active;
  endsequence
  sequence s_ext_held;
    (ext_reset_pin && trip_req == 27'h0) [*4];
  endsequence
  a_trip_lamp_on: assert property (s_trip |=> fault_active && fault_led && !disp_detail)
    else $error("fault not raised on trip");
  a_show_newest: assert property (s_trip |=> ##1 disp_pos == 3'h1)
    else $error("display not moved to newest entry");
  a_code_logged: assert property (s_trip |-> ##2 disp_code == $past(low, 2) && disp_status == $past(st, 2))
    else $error("wrong code or status shown");
  a_lamp_banner: assert property (fault_active |-> fault_led && fault_banner)
    else $error("lamp or banner off during fault");
  a_freeze_reading: assert property (fault_active && $past(fault_active) |-> $stable(disp_current))
    else $error("reading moved during fault");
  a_follow_live: assert property (!$past(rst) && !$past(fault_active) |-> disp_current == $past(avg_current))
    else $error("reading not following input");
  a_ext_clears: assert property (s_ext_held |-> !fault_active)
    else $error("external reset did not clear");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_pos_range: assert property (disp_pos != 3'h0 && disp_pos < 3'h6)
    else $error("display slot out of range");
endmodule
bind fls_fault_log fls_monitor mon (.clk, .rst, .clk_en, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .trip_req,
  .op_status, .motor_running, .avg_current, .ext_reset_pin, .fault_active, .fault_led, .fault_banner, .disp_pos,
  .disp_code, .disp_status, .disp_detail, .disp_current);
`default_nettype wire

// ### sim/fls_keypad_model.sv
// Keypad and external reset input facing the fault log
`default_nettype none
module fls_keypad_model (
  input wire logic clk,
  output logic stop_key_pin,
  output logic ext_reset_pin,
  output logic detail_key_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released keys sit at their pull-down level
  initial
  begin
    stop_key_pin = 1'b0;
    ext_reset_pin = 1'b0;
    detail_key_pin = 1'b0;
  end
  // Key k held n cycles; n of 1 or more so the synchroniser sees it
  task automatic press(input int k, input int n);
    @(posedge clk);
    case (k)
      0: stop_key_pin <= 1'b1;
      1: ext_reset_pin <= 1'b1;
      default: detail_key_pin <= 1'b1;
    endcase
    repeat (n) @(posedge clk);
    {stop_key_pin, ext_reset_pin, detail_key_pin} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### sim/fls_testbench.sv
// Self-checking bench for the fault log and statistics block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 4;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ctl;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [27:1] trip_req;
  logic [4:0] op_status, disp_code, disp_status;
  logic start_pulse, motor_running, stop_key_pin, ext_reset_pin, detail_key_pin, clk_en;
  logic fault_active, fault_led, fault_banner, disp_detail, disp_sep_colon;
  logic [2:0] disp_pos;
  logic [15:0] avg_current, avg_voltage, disp_current, disp_voltage;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] hist[5];
  int miscompares, n_tests, n;
  fls_fault_log #(.SEC_CYCLES(SEC)) dut (.clk, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .trip_req, .op_status, .start_pulse, .motor_running, .avg_current, .avg_voltage, .stop_key_pin, .ext_reset_pin,
    .detail_key_pin, .fault_active, .fault_led, .fault_banner, .disp_pos, .disp_code, .disp_status, .disp_detail,
    .disp_sep_colon, .disp_current, .disp_voltage);
  fls_keypad_model pad (.clk, .stop_key_pin, .ext_reset_pin, .detail_key_pin);
  // Free running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_pin(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
    cmp_pin({6'h0, g}, {6'h0, e});
  endtask
  // Answers meet the oldest note when their handshake completes
  always @(negedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      cmp_bus({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      cmp_bus({s_axi_bresp, 32'h0}, {bq.pop_front(), 32'h0});
  end
  // Each channel held until its own ready; the wait is bounded
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tr, tb;
    int i;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (i = 0; i < 64; i++)
    begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
      @(posedge clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tr)
        s_axi_arvalid <= 1'b0;
      if (tb)
        break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (i == 64)
    begin
      miscompares++;
      conclude();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
    rq.push_back({r, e});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulse;
    start_pulse <= 1'b1;
    @(posedge clk);
    start_pulse <= 1'b0;
    @(posedge clk);
  endtask
  // One trip with noise on higher request bits, then the display is read back
  task automatic trip(input int c);
    logic [4:0] s;
    logic [15:0] v;
    s = 5'($urandom_range(25));
    v = 16'($urandom);
    trip_req <= (27'h1 << (c - 1)) | (27'($urandom) << c);
    op_status <= s;
    {avg_current, avg_voltage} <= {v, v};
    @(posedge clk);
    trip_req <= 27'h0;
    {avg_current, avg_voltage} <= {~v, ~v};
    for (int k = 4; k > 0; k--)
      hist[k] = hist[k - 1];
    hist[0] = {19'h0, s, 3'h0, 5'(c)};
    @(posedge clk);
    @(negedge clk);
    cmp_pin({fault_led, fault_banner, disp_detail, disp_pos}, 6'h31);
    cmp_pin({disp_status, 3'h0, disp_code}, hist[0]);
    cmp_pin({disp_voltage, disp_current, 7'h0, disp_sep_colon}, {v, v, 7'h0, ctl[4]});
    @(posedge clk);
  endtask
  // Watchdog on the whole run
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial
  begin
    void'($urandom(11923));
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    {trip_req, op_status, start_pulse, motor_running, avg_current, avg_voltage} = 66'h0;
    miscompares = 0;
    n_tests = 0;
    clk_en = 1'b1;
    ctl = 32'h0000_0008;
    hist = '{default: 32'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp_pin(disp_pos, 3'h1);
    @(posedge clk);
    rd(6'h00, ctl, 2'h0);
    for (int a = 8; a < 48; a += 4)
      rd(6'(a), 32'h0, 2'h0);
    // Three whole minutes of running give three ticks whatever the prescaler phase
    motor_running <= 1'b1;
    repeat (180 * SEC) @(posedge clk);
    motor_running <= 1'b0;
    @(posedge clk);
    rd(6'h28, 32'h3, 2'h0);
    rd(6'h2C, 32'h3, 2'h0);
    wr(6'h00, ctl | 32'h4, 2'h0);
    rd(6'h2C, 32'h0, 2'h0);
    rd(6'h28, 32'h3, 2'h0);
    // Every fault code, cleared in turn by key, external input and software
    motor_running <= 1'b1;
    for (int c = 1; c < 28; c++)
    begin
      if (c == 14)
      begin
        ctl = 32'h0000_0018;
        wr(6'h00, ctl, 2'h0);
      end
      trip(c);
      if (c == 5)
      begin
        pad.press(2, 4);
        @(negedge clk);
        cmp_pin(disp_detail, 1'b1);
        @(posedge clk);
      end
      if (c % 3 == 2)
        wr(6'h00, ctl | 32'h20, 2'h0);
      else
        pad.press(c % 3, 4);
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp_pin(fault_active, 1'b0);
      @(posedge clk);
    end
    motor_running <= 1'b0;
    for (int k = 0; k < 5; k++)
      rd(6'(12 + 4 * k), hist[k], 2'h0);
    rd(6'h08, hist[0], 2'h0);
    wr(6'h04, 32'h2, 2'h0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_pin({disp_pos, disp_code}, {3'h3, hist[2][4:0]});
    @(posedge clk);
    wr(6'h00, ctl | 32'h1, 2'h0);
    rd(6'h00, ctl, 2'h0);
    for (int k = 0; k < 5; k++)
      rd(6'(12 + 4 * k), 32'h0, 2'h0);
    n = $urandom_range(6, 2);
    repeat (n) pulse();
    rd(6'h20, 32'(n), 2'h0);
    wr(6'h00, ctl | 32'h2, 2'h0);
    rd(6'h24, 32'h0, 2'h0);
    pulse();
    rd(6'h24, 32'h1, 2'h0);
    rd(6'h20, 32'(n + 1), 2'h0);
    // With the clock enable low a start must leave no trace
    clk_en <= 1'b0;
    pulse();
    clk_en <= 1'b1;
    rd(6'h20, 32'(n + 1), 2'h0);
    // Flow trip is ignored while the post-start blanking runs, then logged
    ctl = ctl | 32'h0000_0200;
    wr(6'h00, ctl, 2'h0);
    pulse();
    trip_req <= 27'h1 << 25;
    @(posedge clk);
    trip_req <= 27'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_pin(fault_active, 1'b0);
    repeat (3 * SEC) @(posedge clk);
    trip(26);
    // Unmapped and read-only places
    rd(6'h30, 32'h0, 2'h2);
    wr(6'h30, 32'h1, 2'h2);
    wr(6'h08, 32'h1, 2'h0);
    conclude();
  end
endmodule
`default_nettype wire
